// File: tam_pkg.sv
// Package: register map, field layouts and types of the attribute trigger block
`default_nettype none
package tam_pkg;
    // Register indices; byte address is four times the index
    localparam int         IDX_W           = 6;
    localparam logic [5:0] IDX_ATTR_TRIG_0 = 6'h06;
    localparam logic [5:0] IDX_ATTR_TRIG_1 = 6'h16;
    localparam logic [5:0] IDX_TRIG_CTRL   = 6'h20;
    localparam logic [5:0] IDX_TRIG_STATUS = 6'h21;
    // Reset values
    localparam logic [15:0] ATTR_TRIG_RESET = 16'h0005;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    // Control and status bit positions
    localparam int CTRL_EN0_POS  = 0;
    localparam int CTRL_EN1_POS  = 1;
    localparam int STS_HIT0_POS  = 0;
    localparam int STS_HIT1_POS  = 1;
    localparam int STS_CLS_POS   = 4;
    localparam int STS_LVL_POS   = 8;
    localparam int STS_CNT0_POS  = 16;
    localparam int STS_CNT1_POS  = 24;
    localparam int ATTR_BITS     = 16;
    // Transfer modifier codes
    localparam logic [2:0] TM_LINE_PUSH  = 3'h0;
    localparam logic [2:0] TM_USER_DATA  = 3'h1;
    localparam logic [2:0] TM_USER_CODE  = 3'h2;
    localparam logic [2:0] TM_ICACHE_INV = 3'h3;
    localparam logic [2:0] TM_DCACHE_PSH = 3'h4;
    localparam logic [2:0] TM_SUPER_DATA = 3'h5;
    localparam logic [2:0] TM_TOUCH      = 3'h7;
    localparam logic [2:0] TM_EMU_DATA   = 3'h5;
    localparam logic [2:0] TM_CPU_SPACE  = 3'h0;

    typedef enum logic [1:0] {
        SZ_LONG = 2'h0, SZ_BYTE = 2'h1, SZ_WORD = 2'h2, SZ_RSVD = 2'h3
    } tam_size_t;
    typedef enum logic [1:0] {
        TT_NORMAL = 2'h0, TT_EXT_DMA = 2'h1, TT_EMU = 2'h2, TT_ACK = 2'h3
    } tam_tt_t;
    typedef enum logic [3:0] {
        CLS_RESERVED = 4'h0, CLS_LINE_PUSH = 4'h1, CLS_USER_DATA = 4'h2,
        CLS_USER_CODE = 4'h3, CLS_ICACHE_INV = 4'h4, CLS_DCACHE_PSH = 4'h5,
        CLS_SUPER_DATA = 4'h6, CLS_TOUCH = 4'h7, CLS_EMU_DATA = 4'h8,
        CLS_CPU_SPACE = 4'h9, CLS_INT_ACK = 4'hA
    } tam_cls_t;
    typedef enum logic [1:0] {WB_IDLE = 2'b00, WB_ACK = 2'b01} tam_wb_st_t;

    typedef struct packed {
        logic       rw;
        tam_size_t  size;
        tam_tt_t    tt;
        logic [2:0] tm;
    } tam_attr_t;
    typedef struct packed {
        logic       rw_mask;
        logic [1:0] size_mask;
        logic [1:0] tt_mask;
        logic [2:0] tm_mask;
        tam_attr_t  cmp;
    } tam_cfg_t;
    typedef struct packed {
        tam_cls_t   cls;
        logic [2:0] level;
    } tam_cls_info_t;

    // True when every unmasked bit of a field agrees
    function automatic logic fld_hit(input logic [2:0] a, input logic [2:0] b,
                                     input logic [2:0] m);
        return ((a ^ b) & ~m) == 3'h0;
    endfunction
endpackage
`default_nettype wire

// File: tam_attr_cmp.sv
// Masked comparison of one programmed attribute set against a bus transfer
`timescale 1ns/10ps
`default_nettype none
module tam_attr_cmp (
    // Programmed attributes and transfer
    input  wire tam_pkg::tam_cfg_t  cfg_i,
    input  wire tam_pkg::tam_attr_t attr_i,
    // Result
    output logic                    hit_o
);
    logic rw_ok;
    logic size_ok;
    logic tt_ok;
    logic tm_ok;

    assign rw_ok   = tam_pkg::fld_hit({2'h0, cfg_i.cmp.rw}, {2'h0, attr_i.rw},
                                      {2'h0, cfg_i.rw_mask}); // see RULE_02 RULE_06
    assign size_ok = tam_pkg::fld_hit({1'b0, cfg_i.cmp.size}, {1'b0, attr_i.size},
                                      {1'b0, cfg_i.size_mask}); // see RULE_03 RULE_07
    assign tt_ok   = tam_pkg::fld_hit({1'b0, cfg_i.cmp.tt}, {1'b0, attr_i.tt},
                                      {1'b0, cfg_i.tt_mask}); // see RULE_04 RULE_08
    assign tm_ok   = tam_pkg::fld_hit(cfg_i.cmp.tm, attr_i.tm,
                                      cfg_i.tm_mask); // see RULE_05 RULE_10
    assign hit_o   = rw_ok & size_ok & tt_ok & tm_ok; // see RULE_16
endmodule
`default_nettype wire

// File: tam_cls_dec.sv
// Classifies a transfer from its type and modifier codes
`timescale 1ns/10ps
`default_nettype none
module tam_cls_dec (
    // Transfer
    input  wire tam_pkg::tam_attr_t     attr_i,
    // Class and interrupt level
    output tam_pkg::tam_cls_info_t      info_o
);
    always_comb
    begin
        info_o.cls   = tam_pkg::CLS_RESERVED;
        info_o.level = 3'h0;
        case (attr_i.tt) // see RULE_10
            tam_pkg::TT_NORMAL:
            begin
                case (attr_i.tm) // see RULE_11
                    tam_pkg::TM_LINE_PUSH:  info_o.cls = tam_pkg::CLS_LINE_PUSH;
                    tam_pkg::TM_USER_DATA:  info_o.cls = tam_pkg::CLS_USER_DATA;
                    tam_pkg::TM_USER_CODE:  info_o.cls = tam_pkg::CLS_USER_CODE;
                    tam_pkg::TM_ICACHE_INV: info_o.cls = tam_pkg::CLS_ICACHE_INV;
                    tam_pkg::TM_DCACHE_PSH: info_o.cls = tam_pkg::CLS_DCACHE_PSH;
                    tam_pkg::TM_SUPER_DATA: info_o.cls = tam_pkg::CLS_SUPER_DATA;
                    tam_pkg::TM_TOUCH:      info_o.cls = tam_pkg::CLS_TOUCH;
                    default:                info_o.cls = tam_pkg::CLS_RESERVED;
                endcase
            end
            tam_pkg::TT_EMU:
            begin
                if (attr_i.tm == tam_pkg::TM_EMU_DATA) // see RULE_12
                    info_o.cls = tam_pkg::CLS_EMU_DATA;
            end
            tam_pkg::TT_ACK:
            begin
                if (attr_i.tm == tam_pkg::TM_CPU_SPACE) // see RULE_13
                    info_o.cls = tam_pkg::CLS_CPU_SPACE;
                else
                begin
                    info_o.cls   = tam_pkg::CLS_INT_ACK;
                    info_o.level = attr_i.tm;
                end
            end
            default: info_o.cls = tam_pkg::CLS_RESERVED;
        endcase
    end
endmodule
`default_nettype wire

// File: tam_trig_match.sv
// Two attribute trigger comparators with their Wishbone register file
//
// How it works
// RULE_01 - Both registers compare every bus transfer; control enables gate each result.
// RULE_02 - Direction mask bit 15 removes the read/write bit from the comparison.
// RULE_03 - Size mask bits 14-13 remove matching size bits from the comparison.
// RULE_04 - Type mask bits 12-11 remove matching transfer type bits.
// RULE_05 - Modifier mask bits 10-8 remove matching modifier bits.
// RULE_06 - Direction bit 7 is compared with the bus read/write signal.
// RULE_07 - Size bits 6-5 compared with bus size: 00 long, 01 byte, 10 word.
// RULE_08 - Type bits 4-3: 00 normal, 10 emulator, 11 acknowledge or CPU space.
// RULE_09 - Type field also drives debug-port commands; code 01 means external/DMA access.
// RULE_10 - Modifier meaning depends on the transfer type field.
// RULE_11 - Normal modifiers: push, user data/code, invalidate, push, supervisor, touch.
// RULE_12 - Emulator modifiers up to 100 reserved; 101 is emulator data access.
// RULE_13 - Acknowledge modifier 000 is CPU space; 001-111 interrupt acknowledge 1-7.
// RULE_14 - Modifier field also drives the debug-port command modifier.
// RULE_15 - Registers are whole 32-bit words; unused upper bits are ignored.
// RULE_16 - Match only when all unmasked bits agree, once per transfer.
`timescale 1ns/10ps
`default_nettype none
module tam_trig_match #(
    parameter int CNT_W = 8
) (
    // Clock, reset, enable
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    // Local bus transfer attributes
    input  wire logic                   bus_valid_i,
    input  wire tam_pkg::tam_attr_t     bus_attr_i,
    // Trigger results
    output logic [1:0]                  match_o,
    output tam_pkg::tam_cls_info_t      match_cls_o,
    // Debug-port memory command attributes
    output tam_pkg::tam_attr_t          dbg_cmd_attr_o,
    output logic                        dbg_ext_dma_o
);
    typedef struct packed {
        tam_pkg::tam_wb_st_t    st;
        logic [31:0]            rdata;
        tam_pkg::tam_cfg_t      cfg0;
        tam_pkg::tam_cfg_t      cfg1;
        logic [1:0]             en;
        logic [1:0]             sticky;
        logic [1:0]             match;
        tam_pkg::tam_cls_info_t last;
        logic [CNT_W-1:0]       cnt0;
        logic [CNT_W-1:0]       cnt1;
    } tam_state_t;

    localparam tam_state_t ST_RESET = '{
        st:     tam_pkg::WB_IDLE,
        rdata:  32'h0000_0000,
        cfg0:   tam_pkg::tam_cfg_t'(tam_pkg::ATTR_TRIG_RESET),
        cfg1:   tam_pkg::tam_cfg_t'(tam_pkg::ATTR_TRIG_RESET),
        en:     tam_pkg::CTRL_RESET,
        sticky: 2'h0,
        match:  2'h0,
        last:   tam_pkg::tam_cls_info_t'(7'h00),
        cnt0:   '0,
        cnt1:   '0
    };

    tam_state_t             s_q;
    tam_state_t             s_d;
    logic                   hit0;
    logic                   hit1;
    tam_pkg::tam_cls_info_t cls_now;
    logic [1:0]             evt;
    logic [31:0]            rd_word;
    logic [5:0]             idx;
    logic                   wr_stb;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        return (&c) ? c : c + {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction

    tam_attr_cmp u_cmp0 (
        .cfg_i  (s_q.cfg0),
        .attr_i (bus_attr_i),
        .hit_o  (hit0)
    );

    tam_attr_cmp u_cmp1 (
        .cfg_i  (s_q.cfg1),
        .attr_i (bus_attr_i),
        .hit_o  (hit1)
    );

    tam_cls_dec u_dec (
        .attr_i (bus_attr_i),
        .info_o (cls_now)
    );

    assign idx    = wb_adr_i[7:2];
    // Writes land at the edge where ack is seen; partial words are dropped
    assign wr_stb = ce_i && (s_q.st == tam_pkg::WB_ACK) && wb_cyc_i && wb_stb_i
                    && wb_we_i && (wb_sel_i == 4'hF); // see RULE_15
    // One evaluation per transfer strobe, gated by the enables
    assign evt    = bus_valid_i ? ({hit1, hit0} & s_q.en) : 2'h0; // see RULE_01 RULE_16

    always_comb
    begin
        s_d     = s_q;
        rd_word = 32'h0000_0000;
        case (idx)
            tam_pkg::IDX_ATTR_TRIG_0: rd_word[15:0] = s_q.cfg0;
            tam_pkg::IDX_ATTR_TRIG_1: rd_word[15:0] = s_q.cfg1;
            tam_pkg::IDX_TRIG_CTRL:   rd_word[1:0]  = s_q.en;
            tam_pkg::IDX_TRIG_STATUS:
            begin
                rd_word[tam_pkg::STS_HIT0_POS]      = s_q.sticky[0];
                rd_word[tam_pkg::STS_HIT1_POS]      = s_q.sticky[1];
                rd_word[tam_pkg::STS_CLS_POS +: 4]  = s_q.last.cls;
                rd_word[tam_pkg::STS_LVL_POS +: 3]  = s_q.last.level;
                rd_word[tam_pkg::STS_CNT0_POS +: 8] = s_q.cnt0[7:0];
                rd_word[tam_pkg::STS_CNT1_POS +: 8] = s_q.cnt1[7:0];
            end
            default: rd_word = 32'h0000_0000;
        endcase

        case (s_q.st)
            tam_pkg::WB_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    s_d.st    = tam_pkg::WB_ACK;
                    s_d.rdata = rd_word;
                end
            end
            tam_pkg::WB_ACK:
            begin
                s_d.st = tam_pkg::WB_IDLE;
            end
            default: s_d.st = tam_pkg::WB_IDLE;
        endcase

        if (wr_stb)
        begin
            case (idx)
                tam_pkg::IDX_ATTR_TRIG_0:
                    s_d.cfg0 = tam_pkg::tam_cfg_t'(wb_dat_i[15:0]); // see RULE_15
                tam_pkg::IDX_ATTR_TRIG_1:
                    s_d.cfg1 = tam_pkg::tam_cfg_t'(wb_dat_i[15:0]); // see RULE_15
                tam_pkg::IDX_TRIG_CTRL:
                begin
                    s_d.en[0] = wb_dat_i[tam_pkg::CTRL_EN0_POS]; // see RULE_01
                    s_d.en[1] = wb_dat_i[tam_pkg::CTRL_EN1_POS];
                end
                tam_pkg::IDX_TRIG_STATUS:
                begin
                    // Write one to clear a flag and its counter
                    if (wb_dat_i[tam_pkg::STS_HIT0_POS])
                    begin
                        s_d.sticky[0] = 1'b0;
                        s_d.cnt0      = '0;
                    end
                    if (wb_dat_i[tam_pkg::STS_HIT1_POS])
                    begin
                        s_d.sticky[1] = 1'b0;
                        s_d.cnt1      = '0;
                    end
                end
                default: s_d.en = s_q.en;
            endcase
        end

        // Events are applied after clears so a same-cycle set wins
        s_d.match = evt;
        if (evt[0])
        begin
            s_d.sticky[0] = 1'b1;
            s_d.cnt0      = sat_inc(s_d.cnt0);
        end
        if (evt[1])
        begin
            s_d.sticky[1] = 1'b1;
            s_d.cnt1      = sat_inc(s_d.cnt1);
        end
        if (|evt)
            s_d.last = cls_now; // see RULE_10
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= ST_RESET;
        else if (ce_i)
            s_q <= s_d;
    end

    assign wb_ack_o       = ce_i && (s_q.st == tam_pkg::WB_ACK);
    assign wb_dat_o       = s_q.rdata;
    assign match_o        = s_q.match;
    assign match_cls_o    = s_q.last;
    assign dbg_cmd_attr_o = s_q.cfg0.cmp; // see RULE_09 RULE_14
    assign dbg_ext_dma_o  = (s_q.cfg0.cmp.tt == tam_pkg::TT_EXT_DMA); // see RULE_09

    // Checks on the comparator, decoder and register file
    logic [7:0] diff0;
    logic [7:0] msk0;
    logic       take0;
    logic       full0;
    assign diff0 = s_q.cfg0.cmp ^ bus_attr_i;
    assign msk0  = s_q.cfg0[15:8];
    assign take0 = ce_i && bus_valid_i && s_q.en[0];
    assign full0 = take0 && ((diff0 & ~msk0) == 8'h00);

    sequence req_idle_s;
        ce_i && wb_cyc_i && wb_stb_i && (s_q.st == tam_pkg::WB_IDLE);
    endsequence

    sequence wr_attr0_s;
        wr_stb && (idx == tam_pkg::IDX_ATTR_TRIG_0);
    endsequence

    sequence ack_once_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_ack_seq_a: assert property ( // see RULE_15
        @(posedge clk_i) disable iff (rst_i)
        req_idle_s ##1 ce_i |-> ack_once_s)
        else $error("ack not one cycle after request");

    enable_gate_a: assert property ( // see RULE_01
        @(posedge clk_i) disable iff (rst_i)
        ce_i && bus_valid_i && !s_q.en[1] |=> !match_o[1])
        else $error("disabled comparator matched");

    dir_masked_a: assert property ( // see RULE_02
        @(posedge clk_i) disable iff (rst_i)
        take0 && msk0[7] && diff0[7] && ((diff0[6:0] & ~msk0[6:0]) == 7'h00)
        |=> match_o[0])
        else $error("masked direction blocked match");

    size_mask_a: assert property ( // see RULE_03
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ((diff0[6:5] & ~msk0[6:5]) != 2'h0) |=> !match_o[0])
        else $error("unmasked size mismatch matched");

    type_mask_a: assert property ( // see RULE_04
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ((diff0[4:3] & ~msk0[4:3]) != 2'h0) |=> !match_o[0])
        else $error("unmasked type mismatch matched");

    mod_mask_a: assert property ( // see RULE_05
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ((diff0[2:0] & ~msk0[2:0]) != 3'h0) |=> !match_o[0])
        else $error("unmasked modifier mismatch matched");

    dir_compare_a: assert property ( // see RULE_06
        @(posedge clk_i) disable iff (rst_i)
        ce_i && diff0[7] && !msk0[7] |=> !match_o[0])
        else $error("direction mismatch matched");

    size_code_a: assert property ( // see RULE_07
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (s_q.cfg0.cmp.size == tam_pkg::SZ_BYTE) && (msk0[6:5] == 2'h0)
        && (bus_attr_i.size == tam_pkg::SZ_WORD) |=> !match_o[0])
        else $error("byte compare matched word transfer");

    full_hit_a: assert property ( // see RULE_08 RULE_16
        @(posedge clk_i) disable iff (rst_i)
        full0 |=> match_o[0] ##1 (match_o[0] == ($past(ce_i) ? $past(full0) : 1'b1)))
        else $error("full attribute agreement did not match");

    ext_dma_a: assert property ( // see RULE_09
        @(posedge clk_i) disable iff (rst_i)
        wr_attr0_s ##0 (wb_dat_i[4:3] == 2'h1) |=> dbg_ext_dma_o && (dbg_cmd_attr_o.tt == 2'h1))
        else $error("external access code not flagged");

    normal_cls_a: assert property ( // see RULE_10 RULE_11
        @(posedge clk_i) disable iff (rst_i)
        (|evt) && ce_i && (bus_attr_i.tt == tam_pkg::TT_NORMAL) && (bus_attr_i.tm == 3'h5)
        |=> match_cls_o.cls == tam_pkg::CLS_SUPER_DATA)
        else $error("supervisor data not classified");

    emu_cls_a: assert property ( // see RULE_12
        @(posedge clk_i) disable iff (rst_i)
        (|evt) && ce_i && (bus_attr_i.tt == tam_pkg::TT_EMU) && (bus_attr_i.tm <= 3'h4)
        |=> match_cls_o.cls == tam_pkg::CLS_RESERVED)
        else $error("reserved emulator code classified");

    int_ack_a: assert property ( // see RULE_13
        @(posedge clk_i) disable iff (rst_i)
        (|evt) && ce_i && (bus_attr_i.tt == tam_pkg::TT_ACK) && (bus_attr_i.tm != 3'h0)
        |=> (match_cls_o.cls == tam_pkg::CLS_INT_ACK)
            && (match_cls_o.level == $past(bus_attr_i.tm)))
        else $error("interrupt acknowledge level wrong");

    cmd_mod_a: assert property ( // see RULE_14
        @(posedge clk_i) disable iff (rst_i)
        wr_attr0_s |=> dbg_cmd_attr_o.tm == $past(wb_dat_i[2:0]))
        else $error("command modifier not taken from write");

    part_write_a: assert property ( // see RULE_15
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (s_q.st == tam_pkg::WB_ACK) && wb_we_i && (wb_sel_i != 4'hF)
        |=> $stable(s_q.cfg0) && $stable(s_q.cfg1) && $stable(s_q.en))
        else $error("partial write changed a register");

    once_per_xfer_a: assert property ( // see RULE_16
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !bus_valid_i |=> match_o == 2'h0)
        else $error("match without a transfer");

    ce_freeze_a: assert property ( // see RULE_16
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(s_q))
        else $error("state moved with enable low");

    set_wins_a: assert property ( // see RULE_16
        @(posedge clk_i) disable iff (rst_i)
        ce_i && evt[0] |=> s_q.sticky[0] && (s_q.cnt0 != '0))
        else $error("match event lost");

    flag_clear_a: assert property ( // see RULE_16
        @(posedge clk_i) disable iff (rst_i)
        wr_stb && (idx == tam_pkg::IDX_TRIG_STATUS) && wb_dat_i[tam_pkg::STS_HIT1_POS] && !evt[1]
        |=> !s_q.sticky[1] && (s_q.cnt1 == '0))
        else $error("status flag not cleared");

    attr_write_a: assert property ( // see RULE_15
        @(posedge clk_i) disable iff (rst_i)
        wr_attr0_s |=> s_q.cfg0 == $past(wb_dat_i[15:0]))
        else $error("attribute write not stored");

    ctrl_write_a: assert property ( // see RULE_01
        @(posedge clk_i) disable iff (rst_i)
        wr_stb && (idx == tam_pkg::IDX_TRIG_CTRL) |=> s_q.en == $past(wb_dat_i[1:0]))
        else $error("enable write not stored");

    read_latch_a: assert property ( // see RULE_15
        @(posedge clk_i) disable iff (rst_i)
        req_idle_s ##0 (idx == tam_pkg::IDX_ATTR_TRIG_0)
        |=> wb_dat_o == {16'h0000, $past(s_q.cfg0)})
        else $error("read data not latched");
endmodule
`default_nettype wire

// File: tam_bus_model.sv
// Local bus transfer source standing in for the processor core
`timescale 1ns/10ps
`default_nettype none
module tam_bus_model (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Transfer request from the bench
    input  wire logic               req_i,
    input  wire tam_pkg::tam_attr_t attr_i,
    // Local bus attribute lines
    output logic                    bus_valid_o,
    output tam_pkg::tam_attr_t      bus_attr_o
);
    tam_pkg::tam_attr_t last_q;

    // Between transfers the attribute lines churn so stale values never match by accident
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            last_q <= '0;
        else if (req_i)
            last_q <= attr_i;
        else
            last_q <= tam_pkg::tam_attr_t'(~last_q);
    end

    assign bus_valid_o = req_i;
    assign bus_attr_o  = req_i ? attr_i : tam_pkg::tam_attr_t'(~last_q);
endmodule
`default_nettype wire

// File: tam_trig_match_tb.sv
// Self-checking testbench of the two attribute trigger comparators
`timescale 1ns/10ps
`default_nettype none
module tam_trig_match_tb;
    logic                   clk_i     = 1'b0;
    logic                   rst_i     = 1'b1;
    logic                   ce_i      = 1'b1;
    logic                   wb_cyc_i  = 1'b0;
    logic                   wb_stb_i  = 1'b0;
    logic                   wb_we_i   = 1'b0;
    logic [7:0]             wb_adr_i  = 8'h00;
    logic [3:0]             wb_sel_i  = 4'h0;
    logic [31:0]            wb_dat_i  = 32'h0000_0000;
    logic [31:0]            wb_dat_o;
    logic                   wb_ack_o;
    logic                   bus_valid_i;
    tam_pkg::tam_attr_t     bus_attr_i;
    logic [1:0]             match_o;
    tam_pkg::tam_cls_info_t match_cls_o;
    tam_pkg::tam_attr_t     dbg_cmd_attr_o;
    logic                   dbg_ext_dma_o;
    logic                   req       = 1'b0;
    tam_pkg::tam_attr_t     attr      = '0;
    integer                 seed      = 32'h1baee001;
    int                     mismatches = 0;
    int                     compares  = 0;
    logic [15:0]            cfg [2]   = '{16'h0005, 16'h0005};
    logic [1:0]             en        = 2'b00;
    logic [1:0]             exp_m     = 2'b00;
    logic [6:0]             exp_c     = 7'h00;
    logic [7:0]             pa        = 8'h00;
    logic [31:0]            rd;
    logic [31:0]            exp_s;
    logic [7:0]             hits [2]  = '{8'h00, 8'h00};
    logic [15:0]            corner [8] = '{16'h0080, 16'h8080, 16'h0040, 16'h4040,
                                           16'h0010, 16'h1010, 16'h0404, 16'h0008};

    always #10 clk_i = ~clk_i;

    tam_trig_match #(.CNT_W(8)) i_tam_trig_match (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_valid_i,
        .bus_attr_i, .match_o, .match_cls_o, .dbg_cmd_attr_o, .dbg_ext_dma_o);

    tam_bus_model i_tam_bus_model (.clk_i, .rst_i, .req_i(req), .attr_i(attr),
        .bus_valid_o(bus_valid_i), .bus_attr_o(bus_attr_i));

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic hit(input logic [15:0] r, input logic [7:0] a);
        return ((r[7:0] ^ a) & ~r[15:8]) == 8'h00;
    endfunction

    // Class and interrupt level of a transfer, from its type and modifier
    function automatic logic [6:0] cls(input logic [7:0] a);
        case (a[4:3])
            2'h0: return (a[2:0] == 3'h6) ? 7'h00 :
                         {((a[2:0] == 3'h7) ? 4'h7 : {1'b0, a[2:0]} + 4'h1), 3'h0};
            2'h2: return (a[2:0] == 3'h5) ? 7'h40 : 7'h00;
            2'h3: return (a[2:0] == 3'h0) ? 7'h48 : {4'hA, a[2:0]};
            default: return 7'h00;
        endcase
    endfunction

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            mismatches++;
            results();
        end
        @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (w && s == 4'hF && a == 8'h18)
            cfg[0] = d[15:0];
        if (w && s == 4'hF && a == 8'h58)
            cfg[1] = d[15:0];
        if (w && s == 4'hF && a == 8'h80)
            en = d[1:0];
    endtask

    // One bus cycle: drives the next transfer and checks the one before it
    task automatic step(input logic v, input logic [7:0] a);
        @(posedge clk_i);
        req  <= v;
        attr <= tam_pkg::tam_attr_t'(a);
        #1;
        chk("match", {30'h0, exp_m}, {30'h0, match_o});
        if (exp_m != 2'b00)
            exp_c = cls(pa);
        chk("class", {28'h0, exp_c[6:3]}, {28'h0, match_cls_o.cls});
        if (exp_c[6:3] == 4'hA)
            chk("level", {29'h0, exp_c[2:0]}, {29'h0, match_cls_o.level});
        exp_m = v ? {en[1] & hit(cfg[1], a), en[0] & hit(cfg[0], a)} : 2'b00;
        for (int i = 0; i < 2; i++)
            if (exp_m[i] && hits[i] != 8'hFF)
                hits[i] = hits[i] + 8'h01;
        pa = a;
    endtask

    initial
    begin
        #200_000;
        mismatches++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
        chk("attr0 reset", 32'h0000_0005, rd);
        wb(1'b0, 8'h58, 32'h0000_0000, 4'hF);
        chk("attr1 reset", 32'h0000_0005, rd);
        chk("dbg attr", 32'h0000_0005, {24'h0, dbg_cmd_attr_o});
        wb(1'b0, 8'hFC, 32'h0000_0000, 4'hF);
        chk("unmapped", 32'h0000_0000, rd);
        wb(1'b1, 8'h80, 32'h0000_0003, 4'hF);
        // Each mask field alone, against a differing compare bit
        foreach (corner[i])
        begin
            wb(1'b1, 8'h18, {16'hFFFF, corner[i]}, 4'hF);
            wb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
            chk("attr0", {16'h0, corner[i]}, rd);
            chk("dbg attr", {24'h0, corner[i][7:0]}, {24'h0, dbg_cmd_attr_o});
            exp_s = {31'h0, corner[i][4:3] == 2'b01};
            chk("ext dma", exp_s, {31'h0, dbg_ext_dma_o});
            step(1'b1, 8'h00);
            step(1'b0, 8'h00);
        end
        // Partial write is ignored
        wb(1'b1, 8'h58, 32'h0000_FF00, 4'h3);
        wb(1'b0, 8'h58, 32'h0000_0000, 4'hF);
        chk("attr1 sel", {16'h0, cfg[1]}, rd);
        // Every type and modifier code through a fully masked comparator
        wb(1'b1, 8'h58, 32'h0000_FF00, 4'hF);
        wb(1'b1, 8'h80, 32'h0000_0002, 4'hF);
        for (int t = 0; t < 32; t++)
            step(1'b1, {3'($random(seed)), 5'(t)});
        step(1'b0, 8'h00);
        // Enable low holds the match result of the transfer just taken
        step(1'b1, 8'h00);
        @(posedge clk_i);
        req  <= 1'b0;
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
        #1;
        chk("frozen match", {30'h0, exp_m}, {30'h0, match_o});
        exp_c = cls(pa);
        exp_m = 2'b00;
        // Random settings with back-to-back transfers
        repeat (20)
        begin
            wb(1'b1, 8'h18, $random(seed), 4'hF);
            wb(1'b1, 8'h58, $random(seed), 4'hF);
            wb(1'b1, 8'h80, $random(seed), 4'hF);
            repeat (20) step(1'($random(seed)), 8'($random(seed)));
            step(1'b0, 8'h00);
            wb(1'b0, 8'h84, 32'h0000_0000, 4'hF);
            exp_s = {hits[1], hits[0], 5'h00, exp_c[2:0], exp_c[6:3], 2'h0, |hits[1], |hits[0]};
            chk("status", exp_s, rd);
            wb(1'b1, 8'h84, 32'h0000_0003, 4'hF);
            hits = '{8'h00, 8'h00};
        end
        results();
    end
endmodule
`default_nettype wire
